/* adc_serial_control_port.sv */
// serial control and data port of a multichannel converter, with apb control
`default_nettype none
// Function
// [R1] select falling clears counters and control state, enables data in, out, clock; the code acts on it only in ST_IDLE, and ignores it during ST_CONV
// [R2] select rising stops taking data and ignores the serial clock
// [R3] four command bits, first bit first, sampled on first four rising edges
// [R4] next four rising edges shift in four configuration bits
// [R5] command field picks channel, test voltage, or a feature command
// [R6] result output released while select high, driven while select low; the code enables it only on a select fall seen in ST_IDLE
// [R7] first result bit appears at select assertion, order per configuration; the code loads it only on a select fall seen in ST_IDLE
// [R8] each later falling edge advances to the next of remaining 11 bits
// [R9] mux selection takes effect after the fourth rising edge
// [R10] sampling from fourth falling edge until last falling edge
// [R11] last falling edge hands conversion to the internal sequencer
// [R12] interrupt mode: status goes low when the result is ready
// [R13] interrupt mode: a rising serial clock edge returns status high
// [R14] end mode: status low after last falling edge until conversion done
// [R15] mux picks one of 11 inputs or three self-test voltages
// [R16] end mode: status returns high when conversion completes
// [R17] host keeps select low through the whole frame
module adc_serial_control_port
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   // serial pins
   input wire logic cs_n,
   input wire logic io_clk,
   input wire logic data_in,
   output logic data_out,
   output logic data_out_oe,
   output logic status_n
);
   logic cs_s1, cs_s2, cs_s3, clk_s1, clk_s2, clk_s3, din_s1, din_s2;
   logic cs_fall, cs_rise, io_rise, io_fall;
   adc_port_pkg::link_state_t state_reg, state_next;
   logic [3:0] rise_cnt_reg, rise_cnt_next, fall_cnt_reg, fall_cnt_next;
   logic [2:0] in_sr_reg, in_sr_next;
   logic [3:0] command_holding_reg, command_holding_next, cfg_reg, cfg_next;
   logic [3:0] mux_sel_reg, mux_sel_next;
   logic [11:0] out_sr_reg, out_sr_next, result_reg, result_next;
   logic dout_reg, dout_next, oe_reg, oe_next, sampling_reg, sampling_next;
   logic status_n_reg, status_n_next;
   logic [8:0] conv_cnt_reg, conv_cnt_next;
   logic frame_ev, conv_ev, conv_last;
   logic [1:0] ctrl_reg, ctrl_next, stat_reg, stat_next, mask_reg, mask_next;
   logic [11:0] result_in_reg, result_in_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next, pslverr_reg, pslverr_next, irq_reg, irq_next;
   logic int_mode, lsb_first, access, wr_done;
   logic [3:0] shifted;

   // pins are asynchronous to pclk; stages two and three feed the edge logic
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {cs_s1, cs_s2, cs_s3} <= 3'h7;
         {clk_s1, clk_s2, clk_s3} <= 3'h0;
         {din_s1, din_s2} <= 2'h0;
      end
      else
      begin
         {cs_s1, cs_s2, cs_s3} <= {cs_n, cs_s1, cs_s2};
         {clk_s1, clk_s2, clk_s3} <= {io_clk, clk_s1, clk_s2};
         {din_s1, din_s2} <= {data_in, din_s1};
      end
   end

   assign cs_fall = cs_s3 && !cs_s2;
   assign cs_rise = !cs_s3 && cs_s2;
   assign io_rise = !clk_s3 && clk_s2 && !cs_s2; // [R2]
   assign io_fall = clk_s3 && !clk_s2 && !cs_s2; // [R2]
   assign int_mode = ctrl_reg[adc_port_pkg::CTRL_INT_MODE_BIT];
   assign lsb_first = ctrl_reg[adc_port_pkg::CTRL_LSB_FIRST_BIT];
   assign shifted = {in_sr_reg, din_s2};
   assign conv_last = conv_cnt_reg == 9'(adc_port_pkg::CONV_CYCLES - 1);

   always_comb
   begin
      state_next = state_reg;
      rise_cnt_next = rise_cnt_reg;
      fall_cnt_next = fall_cnt_reg;
      in_sr_next = in_sr_reg;
      command_holding_next = command_holding_reg;
      cfg_next = cfg_reg;
      mux_sel_next = mux_sel_reg;
      out_sr_next = out_sr_reg;
      result_next = result_reg;
      dout_next = dout_reg;
      oe_next = oe_reg;
      sampling_next = sampling_reg;
      status_n_next = status_n_reg;
      conv_cnt_next = conv_cnt_reg;
      frame_ev = 1'b0;
      conv_ev = 1'b0;
      case (state_reg)
         adc_port_pkg::ST_IDLE:
         begin
            if (cs_fall)
            begin
               state_next = adc_port_pkg::ST_FRAME; // [R1]
               rise_cnt_next = 4'h0;
               fall_cnt_next = 4'h0;
               in_sr_next = 3'h0;
               sampling_next = 1'b0;
               oe_next = 1'b1; // [R6]
               out_sr_next = result_reg;
               dout_next = lsb_first ? result_reg[0] : result_reg[11]; // [R7]
            end
         end
         adc_port_pkg::ST_FRAME:
         begin
            // an early release aborts the frame, no conversion starts
            if (cs_rise)
            begin
               state_next = adc_port_pkg::ST_IDLE; // [R2]
               sampling_next = 1'b0;
            end
            else
            begin
               if (io_rise)
               begin
                  if (int_mode)
                  begin
                     status_n_next = 1'b1; // [R13]
                  end
                  if (rise_cnt_reg < adc_port_pkg::CFG_RISES)
                  begin
                     rise_cnt_next = rise_cnt_reg + 4'h1;
                     in_sr_next = shifted[2:0];
                  end
                  if (rise_cnt_reg == adc_port_pkg::ADDR_RISES - 4'h1)
                  begin
                     command_holding_next = shifted; // [R3]
                     // codes above the test range are feature commands
                     if (shifted <= adc_port_pkg::LAST_TEST_SEL)
                     begin
                        mux_sel_next = shifted; // [R5] [R9] [R15]
                     end
                  end
                  if (rise_cnt_reg == adc_port_pkg::CFG_RISES - 4'h1)
                  begin
                     cfg_next = shifted; // [R4]
                  end
               end
               if (io_fall)
               begin
                  fall_cnt_next = fall_cnt_reg + 4'h1;
                  if (lsb_first)
                  begin
                     out_sr_next = {1'b0, out_sr_reg[11:1]};
                     dout_next = out_sr_reg[1]; // [R8]
                  end
                  else
                  begin
                     out_sr_next = {out_sr_reg[10:0], 1'b0};
                     dout_next = out_sr_reg[10]; // [R8]
                  end
                  if (fall_cnt_reg == adc_port_pkg::SAMPLE_FALL - 4'h1)
                  begin
                     sampling_next = 1'b1; // [R10]
                  end
                  if (fall_cnt_reg == adc_port_pkg::LAST_FALL - 4'h1)
                  begin
                     sampling_next = 1'b0; // [R10]
                     state_next = adc_port_pkg::ST_CONV; // [R11]
                     conv_cnt_next = 9'h000;
                     frame_ev = 1'b1;
                     if (!int_mode)
                     begin
                        status_n_next = 1'b0; // [R14]
                     end
                  end
               end
            end
         end
         adc_port_pkg::ST_CONV:
         begin
            conv_cnt_next = conv_cnt_reg + 9'h001;
            if (conv_last)
            begin
               state_next = adc_port_pkg::ST_IDLE;
               result_next = result_in_reg;
               conv_ev = 1'b1;
               status_n_next = int_mode ? 1'b0 : 1'b1; // [R12] [R16]
            end
         end
         default:
         begin
            state_next = adc_port_pkg::ST_IDLE;
         end
      endcase
      if (cs_rise)
      begin
         oe_next = 1'b0; // [R6]
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= adc_port_pkg::ST_IDLE;
         rise_cnt_reg <= 4'h0;
         fall_cnt_reg <= 4'h0;
         in_sr_reg <= 3'h0;
         command_holding_reg <= 4'h0;
         cfg_reg <= 4'h0;
         mux_sel_reg <= 4'h0;
         out_sr_reg <= adc_port_pkg::RESULT_RESET;
         result_reg <= adc_port_pkg::RESULT_RESET;
         dout_reg <= 1'b0;
         oe_reg <= 1'b0;
         sampling_reg <= 1'b0;
         status_n_reg <= 1'b1;
         conv_cnt_reg <= 9'h000;
      end
      else
      begin
         state_reg <= state_next;
         rise_cnt_reg <= rise_cnt_next;
         fall_cnt_reg <= fall_cnt_next;
         in_sr_reg <= in_sr_next;
         command_holding_reg <= command_holding_next;
         cfg_reg <= cfg_next;
         mux_sel_reg <= mux_sel_next;
         out_sr_reg <= out_sr_next;
         result_reg <= result_next;
         dout_reg <= dout_next;
         oe_reg <= oe_next;
         sampling_reg <= sampling_next;
         status_n_reg <= status_n_next;
         conv_cnt_reg <= conv_cnt_next;
      end
   end

   // one wait state: pready rises in the second access cycle
   assign access = psel && penable;
   assign wr_done = access && pready_reg && pwrite;

   always_comb
   begin
      ctrl_next = ctrl_reg;
      mask_next = mask_reg;
      result_in_next = result_in_reg;
      stat_next = stat_reg;
      pready_next = access && !pready_reg;
      prdata_next = prdata_reg;
      pslverr_next = 1'b0;
      if (wr_done)
      begin
         if (paddr == adc_port_pkg::CTRL_OFS)
            ctrl_next = pwdata[1:0];
         else if (paddr == adc_port_pkg::MASK_OFS)
            mask_next = pwdata[1:0];
         else if (paddr == adc_port_pkg::STAT_OFS)
            stat_next = stat_reg & ~pwdata[1:0];
         else if (paddr == adc_port_pkg::RESIN_OFS)
            result_in_next = pwdata[11:0];
      end
      // a new event wins over a clear in the same cycle
      stat_next[adc_port_pkg::EV_FRAME_BIT] = stat_next[adc_port_pkg::EV_FRAME_BIT] | frame_ev;
      stat_next[adc_port_pkg::EV_CONV_BIT] = stat_next[adc_port_pkg::EV_CONV_BIT] | conv_ev;
      if (access && !pready_reg)
      begin
         prdata_next = 32'h0000_0000;
         if (paddr == adc_port_pkg::CTRL_OFS)
            prdata_next[1:0] = ctrl_reg;
         else if (paddr == adc_port_pkg::STAT_OFS)
            prdata_next[1:0] = stat_reg;
         else if (paddr == adc_port_pkg::MASK_OFS)
            prdata_next[1:0] = mask_reg;
         else if (paddr == adc_port_pkg::CMD_OFS)
            prdata_next[15:0] = {state_reg == adc_port_pkg::ST_CONV, sampling_reg,
               2'h0, mux_sel_reg, cfg_reg, command_holding_reg};
         else if (paddr == adc_port_pkg::RESIN_OFS)
            prdata_next[11:0] = result_in_reg;
         else if (paddr == adc_port_pkg::RESOUT_OFS)
            prdata_next[11:0] = result_reg;
         else
            pslverr_next = 1'b1;
      end
      irq_next = |(stat_next & mask_next);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= adc_port_pkg::CTRL_RESET;
         mask_reg <= adc_port_pkg::MASK_RESET;
         stat_reg <= 2'h0;
         result_in_reg <= adc_port_pkg::RESULT_RESET;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         irq_reg <= 1'b0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         mask_reg <= mask_next;
         stat_reg <= stat_next;
         result_in_reg <= result_in_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         irq_reg <= irq_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq = irq_reg;
   assign data_out = dout_reg;
   assign data_out_oe = oe_reg;
   assign status_n = status_n_reg;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_last_fall;
      state_reg == adc_port_pkg::ST_FRAME && !cs_rise && io_fall &&
         fall_cnt_reg == adc_port_pkg::LAST_FALL - 4'h1;
   endsequence
   sequence s_conv_end;
      state_reg == adc_port_pkg::ST_CONV && conv_last;
   endsequence
   property p_open;
      state_reg == adc_port_pkg::ST_IDLE && cs_fall |=>
         oe_reg && rise_cnt_reg == 4'h0 && fall_cnt_reg == 4'h0;
   endproperty
   a_open: assert property (p_open) else $error("frame open failed"); // [R1]
   property p_close;
      cs_rise |=> !oe_reg && state_reg != adc_port_pkg::ST_FRAME;
   endproperty
   a_close: assert property (p_close) else $error("frame close failed"); // [R2]
   property p_first_bit;
      state_reg == adc_port_pkg::ST_IDLE && cs_fall |=>
         dout_reg == ($past(lsb_first) ? $past(result_reg[0]) : $past(result_reg[11]));
   endproperty
   a_first_bit: assert property (p_first_bit) else $error("bad first bit"); // [R7]
   property p_advance;
      state_reg == adc_port_pkg::ST_FRAME && !cs_rise && io_fall |=>
         dout_reg == ($past(lsb_first) ? $past(out_sr_reg[1]) : $past(out_sr_reg[10]));
   endproperty
   a_advance: assert property (p_advance) else $error("bad next bit"); // [R8]
   property p_cmd;
      state_reg == adc_port_pkg::ST_FRAME && !cs_rise && io_rise && rise_cnt_reg == 4'h3
         |=> command_holding_reg == $past(shifted) &&
         (mux_sel_reg == $past(shifted) || $past(shifted) > adc_port_pkg::LAST_TEST_SEL);
   endproperty
   a_cmd: assert property (p_cmd) else $error("command not taken"); // [R3] [R9]
   property p_cfg;
      state_reg == adc_port_pkg::ST_FRAME && !cs_rise && io_rise && rise_cnt_reg == 4'h7
         |=> cfg_reg == $past(shifted);
   endproperty
   a_cfg: assert property (p_cfg) else $error("config not taken"); // [R4]
   property p_sample;
      state_reg == adc_port_pkg::ST_FRAME && !cs_rise && io_fall && fall_cnt_reg == 4'h3
         |=> sampling_reg;
   endproperty
   a_sample: assert property (p_sample) else $error("sampling late"); // [R10]
   property p_handoff;
      s_last_fall |=> state_reg == adc_port_pkg::ST_CONV && !sampling_reg;
   endproperty
   a_handoff: assert property (p_handoff) else $error("no handoff"); // [R11]
   property p_int_low;
      s_conv_end and int_mode |=> !status_n_reg && stat_reg[adc_port_pkg::EV_CONV_BIT];
   endproperty
   a_int_low: assert property (p_int_low) else $error("int not low"); // [R12]
   property p_int_clear;
      int_mode && state_reg == adc_port_pkg::ST_FRAME && !cs_rise && io_rise |=> status_n_reg;
   endproperty
   a_int_clear: assert property (p_int_clear) else $error("int not cleared"); // [R13]
   // conversion end lands a fixed count after the last falling edge
   localparam int CONV_WAIT = adc_port_pkg::CONV_CYCLES - 1;
   property p_eoc;
      s_last_fall and !int_mode |=> !status_n_reg ##[CONV_WAIT:CONV_WAIT] s_conv_end;
   endproperty
   a_eoc: assert property (p_eoc) else $error("eoc timing wrong"); // [R14]
   property p_eoc_low;
      s_last_fall and !int_mode |=> !status_n_reg ##1 !status_n_reg;
   endproperty
   a_eoc_low: assert property (p_eoc_low) else $error("eoc not low"); // [R14]
   property p_eoc_high;
      s_conv_end and !int_mode |=> status_n_reg && state_reg == adc_port_pkg::ST_IDLE;
   endproperty
   a_eoc_high: assert property (p_eoc_high) else $error("eoc not high"); // [R16]
endmodule // adc_serial_control_port
`default_nettype wire

/* adc_port_pkg.sv */
// constants and types for the converter serial control port
`default_nettype none
package adc_port_pkg;
   localparam int CLK_MHZ = 100;
   localparam int CONV_TIME_NS = 4000;
   localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int RESULT_BITS = 12;
   localparam logic [3:0] ADDR_RISES = 4'h4;
   localparam logic [3:0] CFG_RISES = 4'h8;
   localparam logic [3:0] SAMPLE_FALL = 4'h4;
   localparam logic [3:0] LAST_FALL = 4'hC;
   localparam logic [3:0] LAST_EXT_CH = 4'hA;
   localparam logic [3:0] LAST_TEST_SEL = 4'hD;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] MASK_OFS = 8'h08;
   localparam logic [7:0] CMD_OFS = 8'h0C;
   localparam logic [7:0] RESIN_OFS = 8'h10;
   localparam logic [7:0] RESOUT_OFS = 8'h14;
   localparam int CTRL_INT_MODE_BIT = 0;
   localparam int CTRL_LSB_FIRST_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam int EV_FRAME_BIT = 0;
   localparam int EV_CONV_BIT = 1;
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam logic [11:0] RESULT_RESET = 12'h000;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h1,
      ST_FRAME = 3'h2,
      ST_CONV = 3'h4
   } link_state_t;
endpackage
`default_nettype wire

/* serial_host_model.sv */
// behavioural serial host that drives the converter port pins
`default_nettype none
module serial_host_model
(
   // serial pins
   output logic cs_n,
   output logic io_clk,
   output logic data_in,
   input wire logic data_out,
   input wire logic data_out_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      cs_n = 1'b1;
      io_clk = 1'b0;
      data_in = 1'b0;
   end
   // fewer than 12 pulses cuts the frame short on purpose
   task automatic frame(input logic [7:0] bits, input int n, output logic [11:0] got,
      output logic oe_seen);
      got = 12'h000;
      // start off the pclk grid so no pin edge meets a sampling edge
      #2;
      cs_n = 1'b0;
      #62.5;
      oe_seen = data_out_oe;
      for (int i = 0; i < n; i++)
      begin
         // past the eighth bit the line toggles so a stale value shows
         data_in = (i < 8) ? bits[7 - i] : ~data_in;
         // result bit has settled half a period after the falling edge
         #62.5 got = {got[10:0], data_out};
         io_clk = 1'b1;
         #62.5 io_clk = 1'b0;
      end
      #62.5 cs_n = 1'b1;
      data_in = ~data_in;
   endtask
endmodule // serial_host_model
`default_nettype wire

/* tb.sv */
// self-checking bench for the converter serial control port
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, pslv;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic cs_n, io_clk, data_in, data_out, data_out_oe, status_n, oe;
   logic [11:0] got;
   int num_errors = 0;
   int check_count = 0;
   adc_serial_control_port uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .cs_n(cs_n),
      .io_clk(io_clk), .data_in(data_in), .data_out(data_out),
      .data_out_oe(data_out_oe), .status_n(status_n));
   serial_host_model host (.cs_n(cs_n), .io_clk(io_clk), .data_in(data_in),
      .data_out(data_out), .data_out_oe(data_out_oe));
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic check(input logic [31:0] act, input logic [31:0] exp);
      check_count++;
      if (act !== exp)
      begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, act, exp);
      end
   endtask
   // ready and read data are taken at the rising edge that completes the access
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge pclk);
      end
      if (n == 20)
         check(32'h0, 32'h1);
      rd = prdata;
      pslv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_conv();
      int n;
      n = 0;
      apb(1'b0, adc_port_pkg::CMD_OFS, 32'h0);
      while (rd[15] !== 1'b0 && n < 200)
      begin
         n++;
         apb(1'b0, adc_port_pkg::CMD_OFS, 32'h0);
      end
      check({31'h0, rd[15]}, 32'h0);
   endtask
   function automatic logic [11:0] rev12(input logic [11:0] v);
      for (int i = 0; i < 12; i++)
         rev12[i] = v[11 - i];
   endfunction
   task automatic t_reset();
      check({status_n, data_out_oe, irq}, 32'h4);
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b0, 8'(4 * i), 32'h0);
         if (i == 3)
            continue;
         check(rd, 32'h0);
      end
      apb(1'b0, 8'h18, 32'h0);
      check({rd[30:0], pslv}, 32'h1);
      $display("test reset done");
   endtask
   task automatic t_eoc();
      int n;
      apb(1'b1, adc_port_pkg::RESIN_OFS, 32'hA5C);
      apb(1'b1, adc_port_pkg::MASK_OFS, 32'h2);
      host.frame(8'h35, 12, got, oe);
      check({31'h0, oe}, 32'h1);
      check({20'h0, got}, 32'h0);
      repeat (8) @(posedge pclk);
      check({status_n, data_out_oe}, 32'h0);
      apb(1'b0, adc_port_pkg::CMD_OFS, 32'h0);
      check(rd & 32'hCFFF, 32'h8353);
      n = 0;
      while (status_n !== 1'b1 && n < 600)
      begin
         n++;
         @(posedge pclk);
      end
      check({31'h0, n > 300}, 32'h1);
      apb(1'b0, adc_port_pkg::STAT_OFS, 32'h0);
      check(rd, 32'h3);
      check({31'h0, irq}, 32'h1);
      apb(1'b0, adc_port_pkg::RESOUT_OFS, 32'h0);
      check(rd, 32'hA5C);
      apb(1'b1, adc_port_pkg::STAT_OFS, 32'h3);
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      host.frame(8'hB0, 12, got, oe);
      check({20'h0, got}, 32'hA5C);
      wait_conv();
      $display("test eoc done");
   endtask
   task automatic t_order();
      apb(1'b1, adc_port_pkg::CTRL_OFS, 32'h2);
      apb(1'b1, adc_port_pkg::RESIN_OFS, 32'h123);
      host.frame(8'h10, 12, got, oe);
      check({20'h0, got}, {20'h0, rev12(12'hA5C)});
      wait_conv();
      host.frame(8'h10, 12, got, oe);
      check({20'h0, got}, {20'h0, rev12(12'h123)});
      wait_conv();
      apb(1'b1, adc_port_pkg::CTRL_OFS, 32'h0);
      $display("test order done");
   endtask
   task automatic t_mux();
      logic [3:0] cmds [6] = '{4'h0, 4'hA, 4'hB, 4'hD, 4'hE, 4'hF};
      logic [3:0] mux;
      mux = 4'h1;
      foreach (cmds[i])
      begin
         host.frame({cmds[i], 4'h6}, 12, got, oe);
         if (cmds[i] <= adc_port_pkg::LAST_TEST_SEL)
            mux = cmds[i];
         apb(1'b0, adc_port_pkg::CMD_OFS, 32'h0);
         check({20'h0, rd[11:0]}, {20'h0, mux, 4'h6, cmds[i]});
         wait_conv();
      end
      $display("test mux done");
   endtask
   task automatic t_abort();
      apb(1'b1, adc_port_pkg::STAT_OFS, 32'h3);
      host.frame(8'h40, 6, got, oe);
      repeat (8) @(posedge pclk);
      check({31'h0, status_n}, 32'h1);
      apb(1'b0, adc_port_pkg::CMD_OFS, 32'h0);
      check({31'h0, rd[15]}, 32'h0);
      apb(1'b0, adc_port_pkg::STAT_OFS, 32'h0);
      check(rd, 32'h0);
      $display("test abort done");
   endtask
   task automatic t_int();
      int n;
      apb(1'b1, adc_port_pkg::CTRL_OFS, 32'h1);
      apb(1'b1, adc_port_pkg::MASK_OFS, 32'h0);
      host.frame(8'h20, 12, got, oe);
      repeat (8) @(posedge pclk);
      check({31'h0, status_n}, 32'h1);
      n = 0;
      while (status_n !== 1'b0 && n < 600)
      begin
         n++;
         @(posedge pclk);
      end
      check({31'h0, n > 300}, 32'h1);
      check({31'h0, irq}, 32'h0);
      host.frame(8'h20, 12, got, oe);
      check({31'h0, status_n}, 32'h1);
      wait_conv();
      $display("test int done");
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      t_reset();
      t_eoc();
      t_order();
      t_mux();
      t_abort();
      t_int();
      end_of_test();
   end
   // whole run needs about 70 us
   initial
   begin
      #500000;
      num_errors++;
      end_of_test();
   end
endmodule // tb
`default_nettype wire
